// *** hw/p1fs_irq_merge.sv ***
`timescale 1ns/1ps
// Merges the inputs of all pins that select one shared interrupt line
module p1fs_irq_merge #(
    parameter int N = 3                         // Number of pins
) (
    input  wire logic [N-1:0] sel_i,            // Per-pin line select
    input  wire logic [N-1:0] pin_i,            // Pin input levels
    output logic [N-1:0]      gated_o,          // Selected pin levels
    output logic              any_o             // Any selected pin high
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (N < 1) begin : g_bad_n
        $error("p1fs_irq_merge needs at least one pin");
    end

    // ----------------------------------------------------------------
    // Gating and merge
    // ----------------------------------------------------------------
    assign gated_o = sel_i & pin_i;             // Unselected pins read 0
    assign any_o   = |gated_o;                  // Any number may share

endmodule : p1fs_irq_merge

// *** hw/p1fs_out_mux.sv ***
`timescale 1ns/1ps
// Fixed-priority output selector for one pin; source N-1 wins
module p1fs_out_mux #(
    parameter int N = 4                         // Number of sources
) (
    input  wire logic [N-1:0] sel_i,            // Source select bits
    input  wire logic [N-1:0] val_i,            // Source output values
    input  wire logic [N-1:0] drv_i,            // Source drive requests
    output logic              pin_val_o,        // Winning value
    output logic              pin_drv_o         // Winning drive request
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (N < 1) begin : g_bad_n
        $error("p1fs_out_mux needs at least one source");
    end

    // ----------------------------------------------------------------
    // Priority scan
    // ----------------------------------------------------------------
    // Lowest index first, so the highest selected index overwrites
    always_comb begin
        pin_val_o = 1'b1;                       // Released pin idles high
        pin_drv_o = 1'b0;
        for (int k = 0; k < N; k++) begin
            if (sel_i[k]) begin
                pin_val_o = val_i[k];
                pin_drv_o = drv_i[k];
            end
        end
    end

endmodule : p1fs_out_mux

// *** hw/p1fs_pkg.sv ***
package p1fs_pkg;

    // ----------------------------------------------------------------
    // Bus widths and register addresses
    // ----------------------------------------------------------------
    localparam int          P1FS_ADDR_W    = 16;       // Bus address width
    localparam int          P1FS_DATA_W    = 8;        // Register width
    localparam int          P1FS_NUM_PINS  = 3;        // Pins 5, 6, 7
    localparam logic [15:0] P1FS_ADDR_PIN5 = 16'hA05D; // Pin 5 select
    localparam logic [15:0] P1FS_ADDR_PIN6 = 16'hA05E; // Pin 6 select
    localparam logic [15:0] P1FS_ADDR_PIN7 = 16'hA05F; // Pin 7 select

    // ----------------------------------------------------------------
    // Reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [7:0]  P1FS_RESET_VAL = 8'h00;    // All functions off
    localparam logic [7:0]  P1FS_MASK_FULL = 8'hFF;    // Pins 5 and 6
    localparam logic [7:0]  P1FS_MASK_PIN7 = 8'hF7;    // Bit 3 unused

    // ----------------------------------------------------------------
    // Common field positions
    // ----------------------------------------------------------------
    localparam int          P1FS_BIT_GPIO  = 0;        // General I/O enable
    localparam int          P1FS_BIT_IRQ0  = 1;        // Irq line 0 select
    localparam int          P1FS_BIT_IRQ1  = 2;        // Irq line 1 select
    localparam int          P1FS_BIT_TOUCH = 7;        // Touch key select

    // Idle level of an unrouted serial or I2C clock input
    localparam logic        P1FS_IDLE_HIGH = 1'b1;

    // ----------------------------------------------------------------
    // Register layouts
    // ----------------------------------------------------------------
    typedef struct packed {
        logic touch_key_a_select;      // Bit 7
        logic i2c_master_clock_select; // Bit 6
        logic i2c_slave2_clock_select; // Bit 5
        logic pwm_ch1_output_select;   // Bit 4
        logic spi_clock_select;        // Bit 3
        logic pin_irq_line1_select;    // Bit 2
        logic pin_irq_line0_select;    // Bit 1
        logic general_io_enable;       // Bit 0
    } p1fs_pin5_t;

    typedef struct packed {
        logic touch_key_b_select;      // Bit 7
        logic lin_uart_rx_select;      // Bit 6
        logic basic_uart_rx_select;    // Bit 5
        logic pwm_ch1_output_select;   // Bit 4
        logic spi_dataout_select;      // Bit 3
        logic pin_irq_line1_select;    // Bit 2
        logic pin_irq_line0_select;    // Bit 1
        logic general_io_enable;       // Bit 0
    } p1fs_pin6_t;

    typedef struct packed {
        logic touch_key_c_select;      // Bit 7
        logic lin_uart_tx_select;      // Bit 6
        logic basic_uart_tx_select;    // Bit 5
        logic pwm_ch0_output_select;   // Bit 4
        logic unused3;                 // Bit 3, reads zero
        logic pin_irq_line1_select;    // Bit 2
        logic pin_irq_line0_select;    // Bit 1
        logic general_io_enable;       // Bit 0
    } p1fs_pin7_t;

    // ----------------------------------------------------------------
    // Peripheral carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic i2c_master_scl_low;      // Master pulls clock low
        logic i2c_slave2_scl_low;      // Slave two stretches clock
        logic spi_sck_out;             // SPI clock value
        logic spi_sck_drive;           // SPI clock driven (master)
        logic spi_mosi_out;            // SPI data out
        logic pwm_ch0_out;             // PWM generator 0
        logic pwm_ch1_out;             // PWM generator 1
        logic lin_uart_tx;             // LIN serial port transmit
        logic basic_uart_tx;           // Basic serial port transmit
    } p1fs_periph_out_t;

    typedef struct packed {
        logic i2c_master_scl_in;       // Clock seen by master
        logic i2c_slave2_scl_in;       // Clock seen by slave two
        logic spi_sck_in;              // Clock seen by SPI
        logic lin_uart_rx;             // LIN serial port receive
        logic basic_uart_rx;           // Basic serial port receive
    } p1fs_periph_in_t;

endpackage : p1fs_pkg

// *** hw/p1fs_top.sv ***
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
// Summary of operation
// (R1) Three 8-bit select registers, reset zero
// (R2) General enable connects pin to I/O logic
// (R3) Line-1 select feeds pin to interrupt 1
// (R4) Line-0 select feeds pin to interrupt 0
// (R5) Many pins may share interrupt line 1
// (R6) Many pins may share interrupt line 0
// (R7) One pin may feed both lines
// (R8) Pin 7 can carry LIN port transmit
// (R9) Pin 7 can carry basic port transmit
// (R10) Master clock select gives open-drain clock pin
// (R11) PWM channel one select drives PWM output
// (R12) Fixed priority resolves conflicting output selects
// (R13) Unused bits read zero, ignore writes
module p1fs_top
    import p1fs_pkg::*;
(
    input  wire logic                            clk_i,
    input  wire logic                            sys_rst_i,
    // Register port
    input  wire logic [p1fs_pkg::P1FS_ADDR_W-1:0] addr_i,
    input  wire logic [p1fs_pkg::P1FS_DATA_W-1:0] wdata_i,
    input  wire logic                            wr_i,
    input  wire logic                            rd_i,
    output logic [p1fs_pkg::P1FS_DATA_W-1:0]     rdata_o,
    // Package pins 5, 6, 7 (index 0 is pin 5)
    input  wire logic [2:0]                      pin_in_i,
    output logic [2:0]                           pin_out_o,
    output logic [2:0]                           pin_oe_n_o,
    // Ordinary I/O logic
    input  wire logic [2:0]                      gpio_out_i,
    input  wire logic [2:0]                      gpio_drive_i,
    output logic [2:0]                           gpio_in_o,
    // Peripherals
    input  wire p1fs_pkg::p1fs_periph_out_t      periph_i,
    output p1fs_pkg::p1fs_periph_in_t            periph_o,
    // Shared pin interrupt condition inputs
    output logic [2:0]                           irq0_pins_o,
    output logic [2:0]                           irq1_pins_o,
    output logic                                 shared_pin_irq_0_o,
    output logic                                 shared_pin_irq_1_o,
    // Touch key analogue enables
    output logic [2:0]                           touch_key_sel_o
);

    import p1fs_pkg::*;

    // ----------------------------------------------------------------
    // Select registers
    // ----------------------------------------------------------------
    p1fs_pin5_t cfg5;                           // Pin 5 selection
    p1fs_pin6_t cfg6;                           // Pin 6 selection
    p1fs_pin7_t cfg7;                           // Pin 7 selection

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire logic hit5;                            // Pin 5 register hit
    wire logic hit6;                            // Pin 6 register hit
    wire logic hit7;                            // Pin 7 register hit
    wire logic [7:0] rd_mux;                    // Selected read value

    assign hit5 = (addr_i == P1FS_ADDR_PIN5);
    assign hit6 = (addr_i == P1FS_ADDR_PIN6);
    assign hit7 = (addr_i == P1FS_ADDR_PIN7);

    // Unmapped addresses read zero rather than holding the bus
    assign rd_mux = hit5 ? cfg5 :
                    hit6 ? cfg6 :
                    hit7 ? (cfg7 & P1FS_MASK_PIN7) : // R13
                    8'h00;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Synchronous reset clears every selection
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg5 <= P1FS_RESET_VAL;             // R1
            cfg6 <= P1FS_RESET_VAL;             // R1
            cfg7 <= P1FS_RESET_VAL;             // R1
        end else if (wr_i) begin
            if (hit5) begin
                cfg5 <= wdata_i & P1FS_MASK_FULL; // R1
            end
            if (hit6) begin
                cfg6 <= wdata_i & P1FS_MASK_FULL; // R1
            end
            if (hit7) begin
                cfg7 <= wdata_i & P1FS_MASK_PIN7; // R13
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rd_mux;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Pin 5 output selection
    // ----------------------------------------------------------------
    // Priority low to high: general I/O, PWM 1, SPI clock,
    // slave-two clock, master clock. The I2C clocks win because a
    // push-pull source fighting an open-drain bus would corrupt it.
    wire logic [4:0] sel5;                      // Pin 5 source selects
    wire logic [4:0] val5;                      // Pin 5 source values
    wire logic [4:0] drv5;                      // Pin 5 drive requests
    wire logic       pin5_val;                  // Pin 5 resolved value
    wire logic       pin5_drv;                  // Pin 5 resolved drive

    assign sel5 = {cfg5.i2c_master_clock_select,
                   cfg5.i2c_slave2_clock_select,
                   cfg5.spi_clock_select,
                   cfg5.pwm_ch1_output_select,
                   cfg5.general_io_enable};
    // Open-drain clocks only ever drive low
    assign val5 = {1'b0,                        // R10
                   1'b0,
                   periph_i.spi_sck_out,
                   periph_i.pwm_ch1_out,        // R11
                   gpio_out_i[0]};
    assign drv5 = {periph_i.i2c_master_scl_low, // R10
                   periph_i.i2c_slave2_scl_low,
                   periph_i.spi_sck_drive,
                   1'b1,                        // R11
                   gpio_drive_i[0]};            // R2

    p1fs_out_mux #(
        .N         (5)
    ) u_mux5 (
        .sel_i     (sel5),                      // R12
        .val_i     (val5),
        .drv_i     (drv5),
        .pin_val_o (pin5_val),
        .pin_drv_o (pin5_drv)
    );

    // ----------------------------------------------------------------
    // Pin 6 output selection
    // ----------------------------------------------------------------
    // Receive selects are inputs only, so they take no drive slot;
    // SPI data out beats PWM 1, which beats general I/O.
    wire logic [2:0] sel6;                      // Pin 6 source selects
    wire logic [2:0] val6;                      // Pin 6 source values
    wire logic [2:0] drv6;                      // Pin 6 drive requests
    wire logic       pin6_val;                  // Pin 6 resolved value
    wire logic       pin6_drv;                  // Pin 6 resolved drive
    wire logic       rx6_sel;                   // A receive owns pin 6

    assign rx6_sel = cfg6.lin_uart_rx_select | cfg6.basic_uart_rx_select;
    // A receive select masks output sources to avoid driving the line
    assign sel6 = {cfg6.spi_dataout_select & ~rx6_sel,
                   cfg6.pwm_ch1_output_select & ~rx6_sel,
                   cfg6.general_io_enable & ~rx6_sel};
    assign val6 = {periph_i.spi_mosi_out,
                   periph_i.pwm_ch1_out,        // R11
                   gpio_out_i[1]};
    assign drv6 = {1'b1,
                   1'b1,                        // R11
                   gpio_drive_i[1]};            // R2

    p1fs_out_mux #(
        .N         (3)
    ) u_mux6 (
        .sel_i     (sel6),                      // R12
        .val_i     (val6),
        .drv_i     (drv6),
        .pin_val_o (pin6_val),
        .pin_drv_o (pin6_drv)
    );

    // ----------------------------------------------------------------
    // Pin 7 output selection
    // ----------------------------------------------------------------
    // LIN transmit beats basic transmit, then PWM 0, then general I/O
    wire logic [3:0] sel7;                      // Pin 7 source selects
    wire logic [3:0] val7;                      // Pin 7 source values
    wire logic [3:0] drv7;                      // Pin 7 drive requests
    wire logic       pin7_val;                  // Pin 7 resolved value
    wire logic       pin7_drv;                  // Pin 7 resolved drive

    assign sel7 = {cfg7.lin_uart_tx_select,     // R8
                   cfg7.basic_uart_tx_select,   // R9
                   cfg7.pwm_ch0_output_select,
                   cfg7.general_io_enable};     // R2
    assign val7 = {periph_i.lin_uart_tx,        // R8
                   periph_i.basic_uart_tx,      // R9
                   periph_i.pwm_ch0_out,
                   gpio_out_i[2]};
    assign drv7 = {1'b1,
                   1'b1,
                   1'b1,
                   gpio_drive_i[2]};

    p1fs_out_mux #(
        .N         (4)
    ) u_mux7 (
        .sel_i     (sel7),                      // R12
        .val_i     (val7),
        .drv_i     (drv7),
        .pin_val_o (pin7_val),
        .pin_drv_o (pin7_drv)
    );

    // ----------------------------------------------------------------
    // Shared pin interrupt lines
    // ----------------------------------------------------------------
    // Each pin has its own select per line, so one pin may sit on
    // both lines and any number of pins may share either line.
    wire logic [2:0] irq0_sel;                  // Line 0 selects
    wire logic [2:0] irq1_sel;                  // Line 1 selects
    wire logic [2:0] irq0_gated;                // Line 0 pin levels
    wire logic [2:0] irq1_gated;                // Line 1 pin levels
    wire logic       irq0_any;                  // Line 0 merged
    wire logic       irq1_any;                  // Line 1 merged

    assign irq0_sel = {cfg7.pin_irq_line0_select,
                       cfg6.pin_irq_line0_select,
                       cfg5.pin_irq_line0_select}; // R4
    assign irq1_sel = {cfg7.pin_irq_line1_select,
                       cfg6.pin_irq_line1_select,
                       cfg5.pin_irq_line1_select}; // R3

    p1fs_irq_merge #(
        .N       (P1FS_NUM_PINS)
    ) u_irq0 (
        .sel_i   (irq0_sel),                    // R6
        .pin_i   (pin_in_i),                    // R7
        .gated_o (irq0_gated),
        .any_o   (irq0_any)
    );

    p1fs_irq_merge #(
        .N       (P1FS_NUM_PINS)
    ) u_irq1 (
        .sel_i   (irq1_sel),                    // R5
        .pin_i   (pin_in_i),                    // R7
        .gated_o (irq1_gated),
        .any_o   (irq1_any)
    );

    // ----------------------------------------------------------------
    // Peripheral input routing
    // ----------------------------------------------------------------
    // Unrouted I2C clocks and receive lines idle high, as a bus would; SPI clock idles low
    // A net, so each field may take its own continuous assignment
    wire p1fs_periph_in_t next_periph;          // Routed inputs
    wire logic [2:0] gpio_en;                   // General I/O enables

    assign gpio_en = {cfg7.general_io_enable,
                      cfg6.general_io_enable,
                      cfg5.general_io_enable};

    assign next_periph.i2c_master_scl_in = cfg5.i2c_master_clock_select
                                         ? pin_in_i[0] : P1FS_IDLE_HIGH;
    assign next_periph.i2c_slave2_scl_in = cfg5.i2c_slave2_clock_select
                                         ? pin_in_i[0] : P1FS_IDLE_HIGH;
    assign next_periph.spi_sck_in        = cfg5.spi_clock_select
                                         & pin_in_i[0];
    assign next_periph.lin_uart_rx       = cfg6.lin_uart_rx_select
                                         ? pin_in_i[1] : P1FS_IDLE_HIGH;
    assign next_periph.basic_uart_rx     = cfg6.basic_uart_rx_select
                                         ? pin_in_i[1] : P1FS_IDLE_HIGH;

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    // Every output leaves from a flop; costs one cycle of latency on
    // each path through the selector, which the peripherals tolerate.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_out_o          <= 3'h7;         // Released, idle high
            pin_oe_n_o         <= 3'h7;         // Not driving
            gpio_in_o          <= 3'h0;
            periph_o           <= 5'h1B;        // Idle highs, SCK low
            irq0_pins_o        <= 3'h0;
            irq1_pins_o        <= 3'h0;
            shared_pin_irq_0_o <= 1'b0;
            shared_pin_irq_1_o <= 1'b0;
            touch_key_sel_o    <= 3'h0;
        end else begin
            pin_out_o          <= {pin7_val, pin6_val, pin5_val};
            pin_oe_n_o         <= ~{pin7_drv, pin6_drv, pin5_drv};
            gpio_in_o          <= gpio_en & pin_in_i;   // R2
            periph_o           <= next_periph;
            irq0_pins_o        <= irq0_gated;           // R4
            irq1_pins_o        <= irq1_gated;           // R3
            shared_pin_irq_0_o <= irq0_any;             // R6
            shared_pin_irq_1_o <= irq1_any;             // R5
            touch_key_sel_o    <= {cfg7.touch_key_c_select,
                                   cfg6.touch_key_b_select,
                                   cfg5.touch_key_a_select};
        end
    end

endmodule : p1fs_top

// *** tb/p1fs_pins.sv ***
`timescale 1ns/1ps
// Board side of the three pins: pulled up, wired with outside devices
module p1fs_pins (
    input  wire logic [2:0] pin_out_i,   // Block output value
    input  wire logic [2:0] pin_oe_n_i,  // Block drives when low
    input  wire logic [2:0] ext_low_i,   // Outside device pulls low
    output logic [2:0]      pin_o        // Resolved line level
);
    // Wired-AND keeps contention from reading as unknown
    assign pin_o = (pin_oe_n_i | pin_out_i) & ~ext_low_i;
endmodule : p1fs_pins

// *** tb/p1fs_props.sv ***
`timescale 1ns/1ps
// Port checks for the pin function selector
module p1fs_chk (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        rd_i,
    input  wire logic [7:0]  rdata_o,
    input  wire logic [2:0]  pin_in_i,
    input  wire logic [2:0]  pin_oe_n_o,
    input  wire logic [2:0]  gpio_in_o,
    input  wire logic [2:0]  irq0_pins_o,
    input  wire logic [2:0]  irq1_pins_o,
    input  wire logic        shared_pin_irq_0_o,
    input  wire logic        shared_pin_irq_1_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Outside the three select addresses
    wire unmapped = addr_i < 16'hA05D || addr_i > 16'hA05F;
    idle_rdata_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero when idle");
    unmapped_read_a: assert property (rd_i && unmapped |=> !rdata_o)
        else $error("unmapped read not zero");
    pin7_bit3_a: assert property (rd_i && addr_i == 16'hA05F |=> !rdata_o[3])
        else $error("pin 7 bit 3 reads one");
    reset_state_a: assert property ($fell(sys_rst_i) |->
        pin_oe_n_o == 3'h7 && irq0_pins_o == 3'h0 && gpio_in_o == 3'h0)
        else $error("outputs not in reset state");
    irq0_or_a: assert property (shared_pin_irq_0_o == |irq0_pins_o)
        else $error("line 0 not the OR of its pins");
    irq1_or_a: assert property (shared_pin_irq_1_o == |irq1_pins_o)
        else $error("line 1 not the OR of its pins");
    irq0_gate_a: assert property ((irq0_pins_o & ~$past(pin_in_i)) == 3'h0)
        else $error("line 0 shows a low pin");
    irq1_gate_a: assert property ((irq1_pins_o & ~$past(pin_in_i)) == 3'h0)
        else $error("line 1 shows a low pin");
    gpio_gate_a: assert property ((gpio_in_o & ~$past(pin_in_i)) == 3'h0)
        else $error("general input shows a low pin");
    cover property (rd_i && addr_i == 16'hA05F);
    cover property (shared_pin_irq_0_o && shared_pin_irq_1_o);
    cover property (pin_oe_n_o == 3'h6);
endmodule : p1fs_chk

bind p1fs_top p1fs_chk p1fs_chk_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_in_i(pin_in_i),
    .pin_oe_n_o(pin_oe_n_o), .gpio_in_o(gpio_in_o),
    .irq0_pins_o(irq0_pins_o), .irq1_pins_o(irq1_pins_o),
    .shared_pin_irq_0_o(shared_pin_irq_0_o),
    .shared_pin_irq_1_o(shared_pin_irq_1_o));

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    import p1fs_pkg::*;
    logic clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0]  wdata_i = 8'h00, rdata_o;
    logic [2:0]  pin_in_i, pin_out_o, pin_oe_n_o, gpio_in_o, touch;
    logic [2:0]  gpio_out_i = 3'h0, gpio_drive_i = 3'h0, ext = 3'h0;
    logic [2:0]  irq0, irq1;
    logic        s0, s1;
    p1fs_periph_out_t per = '0;
    p1fs_periph_in_t  pin_side;
    int num_errors = 0, compares = 0;
    always #2 clk_i = ~clk_i;  // 250 MHz
    p1fs_top p1fs_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
        .pin_oe_n_o(pin_oe_n_o), .gpio_out_i(gpio_out_i),
        .gpio_drive_i(gpio_drive_i), .gpio_in_o(gpio_in_o),
        .periph_i(per), .periph_o(pin_side), .irq0_pins_o(irq0),
        .irq1_pins_o(irq1), .shared_pin_irq_0_o(s0),
        .shared_pin_irq_1_o(s1), .touch_key_sel_o(touch));
    p1fs_pins p1fs_pins_i (.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o),
        .ext_low_i(ext), .pin_o(pin_in_i));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i) begin addr_i <= a; wdata_i <= d; wr_i <= 1; end
        @(posedge clk_i) wr_i <= 0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_i) begin addr_i <= a; rd_i <= 1; end
        @(posedge clk_i) rd_i <= 0;
        #1 chk(rdata_o, e);
    endtask : rd
    // Pin loop needs two edges, output and input register; settle waits three
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle
    task automatic t_regs;
        for (int i = 0; i < 3; i++) begin
            rd(16'hA05D + 16'(i), 8'h00);
            wr(16'hA05D + 16'(i), 8'hFF);
            rd(16'hA05D + 16'(i), i == 2 ? 8'hF7 : 8'hFF);
            chk(8'(touch), 8'(1 << i));
            wr(16'hA05D + 16'(i), 8'h00);
        end
        wr(16'hA060, 8'h55);
        rd(16'hA060, 8'h00);
        rd(16'hA05C, 8'h00);
    endtask : t_regs
    task automatic t_gpio;
        wr(16'hA05D, 8'h01);
        gpio_drive_i <= 3'h7;
        settle();
        chk(8'({pin_out_o, pin_oe_n_o, gpio_in_o}), 8'hB0);
        gpio_out_i <= 3'h7;
        settle();
        chk(8'({pin_out_o, pin_oe_n_o, gpio_in_o}), 8'hF1);
        gpio_drive_i <= 3'h0;
    endtask : t_gpio
    task automatic t_irq;
        wr(16'hA05D, 8'h06);
        wr(16'hA05E, 8'h02);
        wr(16'hA05F, 8'h04);
        settle();
        chk({irq1, irq0, s1, s0}, 8'hAF);
        ext <= 3'h1;
        settle();
        chk({irq1, irq0, s1, s0}, 8'h8B);
        ext <= 3'h0;
    endtask : t_irq
    task automatic t_tx;
        per.basic_uart_tx <= 1;
        per.pwm_ch0_out <= 1;
        wr(16'hA05F, 8'h71);
        settle();
        chk(8'({pin_out_o, pin_oe_n_o}), 8'h1B);
        wr(16'hA05F, 8'h31);
        settle();
        chk(8'({pin_out_o, pin_oe_n_o}), 8'h3B);
        per.basic_uart_tx <= 0;
        settle();
        chk(8'({pin_out_o, pin_oe_n_o}), 8'h1B);
        wr(16'hA05F, 8'h00);
    endtask : t_tx
    task automatic t_i2c;
        per.i2c_master_scl_low <= 1;
        wr(16'hA05D, 8'h50);
        settle();
        chk(8'({pin_out_o, pin_oe_n_o}), 8'h36);
        per.i2c_master_scl_low <= 0;
        ext <= 3'h1;
        settle();
        chk(8'({pin_out_o, pin_oe_n_o, pin_side}), 8'hEB);
        ext <= 3'h0;
        per.pwm_ch1_out <= 1;
        wr(16'hA05D, 8'h10);
        settle();
        chk(8'({pin_out_o, pin_oe_n_o}), 8'h3E);
    endtask : t_i2c
    task automatic print_verdict;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    // Watchdog: whole run is under a hundred cycles
    initial begin
        #8000;
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 0;
        t_regs();
        t_gpio();
        t_irq();
        t_tx();
        t_i2c();
        print_verdict();
    end
endmodule : tb
